// ===== hdl/pfah_pkg.sv
// Package: constants and carrier types for the PCM fault and alarm handler
package pfah_pkg;

  // ---------------------------------------------------------------------------
  // Clock and time
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int ALARM_LIMIT_MS = 2;
  localparam int LOF_LIMIT_MS   = 3;
  localparam int ALARM_LIMIT_CYC = ALARM_LIMIT_MS * 1000 * CLK_MHZ;
  localparam int LOF_LIMIT_CYC   = LOF_LIMIT_MS * 1000 * CLK_MHZ;
  // Evaluation window of the error-ratio monitor, counted in alignment words
  localparam int EVAL_MS        = 4000;
  localparam int FAS_PERIOD_US  = 250;
  localparam int WIN_FAS        = EVAL_MS * 1000 / FAS_PERIOD_US;
  localparam int WIN_W          = 15;
  localparam int ACC_W          = 17;
  localparam logic [ACC_W-1:0] ACC_MAX = 17'h1ffff;

  // ---------------------------------------------------------------------------
  // All-ones detector
  // ---------------------------------------------------------------------------
  localparam int AIS_WIN_BITS              = 512;
  localparam logic [8:0] AIS_LAST_BIT      = 9'h1ff;
  localparam logic [2:0] AIS_MAX_ZEROS     = 3'h2;
  localparam logic [2:0] AIS_ZERO_SAT      = 3'h7;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_THRESH = 8'h04;
  localparam logic [7:0] OFF_FAULTS = 8'h08;
  localparam logic [7:0] OFF_ACTS   = 8'h0c;
  localparam logic [7:0] OFF_ERRCNT = 8'h10;
  localparam int CTRL_SUP_EN = 0;
  localparam int CTRL_AIS_EN = 1;
  localparam logic [1:0]  CTRL_RST    = 2'h3;
  localparam logic [15:0] SET_THR_RST = 16'h0038;
  localparam logic [15:0] CLR_THR_RST = 16'h001c;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic power;
    logic codec;
    logic ts16_los;
    logic sig_los;
    logic lof;
    logic excess;
    logic remote;
  } pfah_faults_t;

  typedef struct packed {
    logic svc;
    logic maint;
    logic ra;
    logic mute;
    logic ais64;
    logic ais_ts16;
  } pfah_acts_t;

  typedef enum logic [0:0] {
    EXE_CLEAR = 1'b0,
    EXE_ALARM = 1'b1
  } pfah_exe_t;

endpackage

// ===== hdl/pfah_ais_det.sv
// All-ones alarm signal detector on the received 2048 kbit/s bit stream
module pfah_ais_det
  import pfah_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic bit_valid,
  input  wire logic bit_in,
  output logic      ais
);

  logic [8:0] bit_cnt_q;
  logic [2:0] zero_cnt_q;
  logic       ais_q;

  // ---------------------------------------------------------------------------
  // Window of one multiplex frame pair
  // ---------------------------------------------------------------------------
  // Any 512-bit window holds one alignment word with three zeros, so a
  // framed all-ones signal never passes; one or two errored bits still do
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_q <= 9'h000;
    end else if (bit_valid) begin
      bit_cnt_q <= bit_cnt_q + 9'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_cnt_q <= 3'h0;
    end else if (bit_valid) begin
      if (bit_cnt_q == AIS_LAST_BIT) begin
        zero_cnt_q <= 3'h0;
      end else if (!bit_in && zero_cnt_q != AIS_ZERO_SAT) begin
        zero_cnt_q <= zero_cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ais_q <= 1'b0;
    end else if (bit_valid && bit_cnt_q == AIS_LAST_BIT) begin
      // A saturated count must not wrap to zero on a final zero bit
      if (bit_in || zero_cnt_q == AIS_ZERO_SAT) begin
        ais_q <= (zero_cnt_q <= AIS_MAX_ZEROS);
      end else begin
        ais_q <= (zero_cnt_q + 3'h1 <= AIS_MAX_ZEROS);
      end
    end
  end

  assign ais = ais_q;

endmodule

// ===== hdl/pfah_top.sv
// Fault supervision and consequent actions of a 2048 kbit/s primary multiplex
module pfah_top
  import pfah_pkg::*;
#(
  parameter int WIN_LEN = WIN_FAS
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        power_fail_pin,
  input  wire logic        codec_fail_pin,
  input  wire logic        ts16_in_lost_pin,
  input  wire logic        fas_chk,
  input  wire logic [2:0]  fas_err_bits,
  input  wire logic        frame_lost,
  input  wire logic        rx_sig_lost,
  input  wire logic        ra_strobe,
  input  wire logic        ra_bit_rx,
  input  wire logic        rx_bit_valid,
  input  wire logic        rx_bit,
  input  wire logic        ts16_rx_valid,
  input  wire logic        ts16_rx_bit,
  input  wire logic        ts16_tx_valid,
  input  wire logic        ts16_tx_in,
  output logic             svc_alarm,
  output logic             maint_alarm,
  output logic             tx_ra_bit,
  output logic             ana_mute,
  output logic             ts16_out_bit,
  output logic             ts16_tx_bit
);

  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WIN_LEN - 1);

  // Consequent actions of all present faults ORed together; AIS masks lof and excess maintenance
  function automatic pfah_acts_t acts_of(input pfah_faults_t f, input logic ais);
    pfah_acts_t a;
    logic       frm;
    frm        = f.sig_los | f.lof | f.excess;
    a.svc      = f.power | f.codec | frm | f.remote;
    a.maint    = f.power | f.codec | f.ts16_los | f.sig_los
               | ((f.lof | f.excess) & ~ais);
    a.ra       = f.power | f.codec | frm;
    a.mute     = f.power | f.codec | frm;
    a.ais64    = f.power | frm;
    a.ais_ts16 = f.power | f.ts16_los;
    return a;
  endfunction

  logic [2:0]       sync1_q;
  logic [2:0]       sync2_q;
  logic             ra_q;
  logic [1:0]       ctrl_q;
  logic [15:0]      set_thr_q;
  logic [15:0]      clr_thr_q;
  logic [WIN_W-1:0] win_cnt_q;
  logic [ACC_W-1:0] err_acc_q;
  logic [ACC_W-1:0] err_last_q;
  pfah_exe_t        exe_q;
  pfah_faults_t     faults_q;
  pfah_acts_t       act_q;
  logic             ais_det;
  logic             ais_seen;
  logic             ts16_out_q;
  logic             ts16_tx_q;
  logic [31:0]      prdata_q;
  logic             pready_q;
  logic             pslverr_q;
  logic             win_end;
  logic [ACC_W-1:0] err_sum;

  // ---------------------------------------------------------------------------
  // Pin synchronisers and remote alarm bit
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {power_fail_pin, codec_fail_pin, ts16_in_lost_pin};
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ra_q <= 1'b0;
    end else if (ra_strobe) begin
      ra_q <= ra_bit_rx;
    end
  end

  // ---------------------------------------------------------------------------
  // Alignment word error ratio monitor
  // ---------------------------------------------------------------------------
  // About 112 errored bits per window at one in a thousand, about 11 at one
  // in ten thousand; the default thresholds sit well apart from both
  assign win_end = fas_chk && (win_cnt_q == WIN_LAST);
  assign err_sum = (err_acc_q > ACC_MAX - ACC_W'(fas_err_bits)) ? ACC_MAX
                 : err_acc_q + ACC_W'(fas_err_bits);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_q <= '0;
    end else if (fas_chk) begin
      win_cnt_q <= win_end ? '0 : win_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_acc_q  <= '0;
      err_last_q <= '0;
    end else if (fas_chk) begin
      err_acc_q <= win_end ? '0 : err_sum;
      if (win_end) begin
        err_last_q <= err_sum;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exe_q <= EXE_CLEAR;
    end else if (win_end) begin
      case (exe_q)
        EXE_CLEAR: exe_q <= (err_sum >= ACC_W'(set_thr_q)) ? EXE_ALARM : EXE_CLEAR;
        EXE_ALARM: exe_q <= (err_sum <  ACC_W'(clr_thr_q)) ? EXE_CLEAR : EXE_ALARM;
        default:   exe_q <= EXE_CLEAR;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Faults and consequent actions
  // ---------------------------------------------------------------------------
  pfah_ais_det u_ais (
    .pclk      (pclk),
    .presetn   (presetn),
    .bit_valid (rx_bit_valid),
    .bit_in    (rx_bit),
    .ais       (ais_det)
  );

  assign ais_seen = ais_det & ctrl_q[CTRL_AIS_EN];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      faults_q <= '0;
    end else begin
      faults_q.power    <= sync2_q[2];
      faults_q.codec    <= sync2_q[1];
      faults_q.ts16_los <= sync2_q[0] & ctrl_q[CTRL_SUP_EN];
      faults_q.sig_los  <= rx_sig_lost;
      faults_q.lof      <= frame_lost;
      faults_q.excess   <= (exe_q == EXE_ALARM);
      faults_q.remote   <= ra_q;
    end
  end

  // Registered both ways so raising and clearing take the same one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= '0;
    end else begin
      act_q <= acts_of(faults_q, ais_seen);
    end
  end

  // Slot 16 carried bit by bit, so either signalling method passes unchanged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts16_out_q <= 1'b1;
      ts16_tx_q  <= 1'b1;
    end else begin
      if (ts16_rx_valid) begin
        ts16_out_q <= ts16_rx_bit | act_q.ais64;
      end
      if (ts16_tx_valid) begin
        ts16_tx_q <= ts16_tx_in | act_q.ais_ts16;
      end
    end
  end

  assign svc_alarm    = act_q.svc;
  assign maint_alarm  = act_q.maint;
  assign tx_ra_bit    = act_q.ra;
  assign ana_mute     = act_q.mute;
  assign ts16_out_bit = ts16_out_q;
  assign ts16_tx_bit  = ts16_tx_q;

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  // Answer prepared in the setup cycle, so every access has no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          OFF_CTRL:   prdata_q <= {30'h0, ctrl_q};
          OFF_THRESH: prdata_q <= {clr_thr_q, set_thr_q};
          OFF_FAULTS: prdata_q <= {23'h0, ais_det, exe_q, faults_q};
          OFF_ACTS:   prdata_q <= {26'h0, act_q};
          OFF_ERRCNT: prdata_q <= {15'h0, err_last_q};
          default:    pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= CTRL_RST;
      set_thr_q <= SET_THR_RST;
      clr_thr_q <= CLR_THR_RST;
    end else if (psel && penable && pready_q && pwrite) begin
      if (paddr == OFF_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end
      if (paddr == OFF_THRESH) begin
        set_thr_q <= pwdata[15:0];
        clr_thr_q <= pwdata[31:16];
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_svc_raise;
    faults_q.lof || faults_q.sig_los || faults_q.codec |-> ##1 svc_alarm;
  endproperty
  a_svc_raise: assert property (p_svc_raise) else $error("service alarm late");

  property p_lof_chain;
    $rose(frame_lost) |-> ##[2:3] (svc_alarm && tx_ra_bit && ana_mute);
  endproperty
  a_lof_chain: assert property (p_lof_chain) else $error("framing loss actions late");

  property p_svc_clear;
    (faults_q == '0) ##1 (faults_q == '0) |-> !svc_alarm && !maint_alarm && !ana_mute;
  endproperty
  a_svc_clear: assert property (p_svc_clear) else $error("actions not removed");

  property p_power_all;
    faults_q.power |=> svc_alarm && maint_alarm && tx_ra_bit && ana_mute
                       && act_q.ais64 && act_q.ais_ts16;
  endproperty
  a_power_all: assert property (p_power_all) else $error("power fault action missing");

  property p_remote_only;
    (faults_q == 7'h01) |=> svc_alarm && !maint_alarm && !tx_ra_bit && !ana_mute
                            && !act_q.ais64 && !act_q.ais_ts16;
  endproperty
  a_remote_only: assert property (p_remote_only) else $error("remote alarm actions wrong");

  property p_ais_mask;
    (faults_q == 7'h04) && ais_seen |=> !maint_alarm && svc_alarm && tx_ra_bit
                                        && act_q.ais64;
  endproperty
  a_ais_mask: assert property (p_ais_mask) else $error("maintenance not masked");

  property p_ts16_los_only;
    (faults_q == 7'h10) |=> maint_alarm && act_q.ais_ts16 && !svc_alarm && !act_q.ais64;
  endproperty
  a_ts16_los_only: assert property (p_ts16_los_only) else $error("slot 16 loss actions wrong");

  property p_ais64_out;
    act_q.ais64 && ts16_rx_valid |=> ts16_out_bit;
  endproperty
  a_ais64_out: assert property (p_ais64_out) else $error("slot 16 output not all ones");

  property p_exe_set;
    win_end && exe_q == EXE_CLEAR && err_sum >= ACC_W'(set_thr_q) |=> exe_q == EXE_ALARM
                                                                  ##1 faults_q.excess;
  endproperty
  a_exe_set: assert property (p_exe_set) else $error("error alarm not set");

  property p_exe_hold;
    !win_end && exe_q == EXE_ALARM |=> exe_q == EXE_ALARM;
  endproperty
  a_exe_hold: assert property (p_exe_hold) else $error("error alarm left mid window");

  property p_win_len;
    fas_chk |-> win_cnt_q <= WIN_LAST;
  endproperty
  a_win_len: assert property (p_win_len) else $error("window counter overran");

endmodule

// ===== bench/pfah_far_end.sv
// Far-end model: remote multiplex bit stream, alignment checks and slot-16 bits
module pfah_far_end (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] err_cfg,
  input  wire logic       ra_cfg,
  input  wire logic [1:0] rx_mode,
  output logic            fas_chk,
  output logic [2:0]      fas_err_bits,
  output logic            ra_strobe,
  output logic            ra_bit_rx,
  output logic            rx_bit_valid,
  output logic            rx_bit,
  output logic            ts16_rx_valid,
  output logic            ts16_rx_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= cnt_q + 9'h001;
    end
  end

  // Strobed values only mean something on their strobe; junk elsewhere
  assign fas_chk       = (cnt_q[3:0] == 4'h0);
  assign fas_err_bits  = fas_chk ? err_cfg : ~err_cfg;
  assign ra_strobe     = (cnt_q[3:0] == 4'h8);
  assign ra_bit_rx     = ra_strobe ? ra_cfg : ~ra_cfg;
  assign rx_bit_valid  = presetn;
  assign ts16_rx_valid = (cnt_q[2:0] == 3'h3);
  assign ts16_rx_bit   = ~ts16_rx_valid;
  // Mode 1: all ones with one error per 512 bits; mode 2: ones plus alignment zeros
  always_comb begin
    case (rx_mode)
      2'h1:    rx_bit = (cnt_q != 9'h064);
      2'h2:    rx_bit = !(cnt_q[8:3] == 6'h00 && (cnt_q[2:0] inside {3'h1, 3'h2, 3'h5}));
      default: rx_bit = cnt_q[0];
    endcase
  end
endmodule

// ===== bench/tb_top.sv
// Testbench: fault table, all-ones masking, error monitor and registers
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pfah_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr;
  logic        power_fail_pin, codec_fail_pin, ts16_in_lost_pin, frame_lost, rx_sig_lost;
  logic        fas_chk, ra_strobe, ra_bit_rx, rx_bit_valid, rx_bit, ts16_rx_valid, ts16_rx_bit;
  logic [2:0]  fas_err_bits, err_cfg;
  logic [1:0]  rx_mode;
  logic        ra_cfg, ts16_tx_valid, ts16_tx_in;
  logic        svc_alarm, maint_alarm, tx_ra_bit, ana_mute, ts16_out_bit, ts16_tx_bit;
  logic [5:0]  acts;
  int          failures, n_tests, cyc;
  // Fault order {power, codec, slot16 loss, input loss, framing loss, remote}
  localparam logic [5:0] FLT [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h09};
  localparam logic [5:0] EXP [7] = '{6'h3f, 6'h3c, 6'h11, 6'h3e, 6'h3e, 6'h20, 6'h31};
  assign acts = {svc_alarm, maint_alarm, tx_ra_bit, ana_mute, ts16_out_bit, ts16_tx_bit};

  pfah_top #(.WIN_LEN(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_fail_pin(power_fail_pin),
    .codec_fail_pin(codec_fail_pin), .ts16_in_lost_pin(ts16_in_lost_pin), .fas_chk(fas_chk),
    .fas_err_bits(fas_err_bits), .frame_lost(frame_lost), .rx_sig_lost(rx_sig_lost),
    .ra_strobe(ra_strobe), .ra_bit_rx(ra_bit_rx), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .ts16_rx_valid(ts16_rx_valid), .ts16_rx_bit(ts16_rx_bit), .ts16_tx_valid(ts16_tx_valid),
    .ts16_tx_in(ts16_tx_in), .svc_alarm(svc_alarm), .maint_alarm(maint_alarm),
    .tx_ra_bit(tx_ra_bit), .ana_mute(ana_mute), .ts16_out_bit(ts16_out_bit),
    .ts16_tx_bit(ts16_tx_bit));

  pfah_far_end i_far (.pclk(pclk), .presetn(presetn), .err_cfg(err_cfg), .ra_cfg(ra_cfg),
    .rx_mode(rx_mode), .fas_chk(fas_chk), .fas_err_bits(fas_err_bits), .ra_strobe(ra_strobe),
    .ra_bit_rx(ra_bit_rx), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .ts16_rx_valid(ts16_rx_valid), .ts16_rx_bit(ts16_rx_bit));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check("read data", rd, exp);
    check("slave error", {31'h0, err}, {31'h0, eexp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic eexp);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    check("write error", {31'h0, err}, {31'h0, eexp});
  endtask

  task automatic apply(input logic [5:0] f, input int wait_cyc);
    @(posedge pclk);
    {power_fail_pin, codec_fail_pin, ts16_in_lost_pin, rx_sig_lost, frame_lost, ra_cfg} <= f;
    repeat (wait_cyc) @(posedge pclk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    reg_chk(OFF_CTRL, 32'h0000_0003, 1'b0);
    reg_chk(OFF_THRESH, 32'h001c_0038, 1'b0);
    wr(8'h14, 32'hffff_ffff, 1'b1);
    reg_chk(8'h14, 32'h0, 1'b1);
    wr(OFF_FAULTS, 32'hffff_ffff, 1'b0);
    reg_chk(OFF_FAULTS, 32'h0, 1'b0);
    wr(OFF_CTRL, 32'h0000_0002, 1'b0);
    apply(6'h08, 24);
    check("unsupervised slot16 loss", {26'h0, acts}, 32'h0);
    apply(6'h00, 24);
    wr(OFF_CTRL, 32'h0000_0003, 1'b0);
    $display("registers done");
  endtask

  task automatic t_table();
    for (int i = 0; i < 7; i++) begin
      apply(FLT[i], 24);
      check("actions", {26'h0, acts}, {26'h0, EXP[i]});
      apply(6'h00, 24);
      check("actions removed", {26'h0, acts}, 32'h0);
    end
    $display("fault table done");
  endtask

  task automatic t_ais();
    @(posedge pclk);
    rx_mode <= 2'h1;
    apply(6'h02, 1100);
    check("framing loss under all-ones", {26'h0, acts}, 32'h2e);
    reg_chk(OFF_FAULTS, 32'h0000_0104, 1'b0);
    wr(OFF_CTRL, 32'h0000_0001, 1'b0);
    repeat (4) @(posedge pclk);
    check("masking disabled", {26'h0, acts}, 32'h3e);
    wr(OFF_CTRL, 32'h0000_0003, 1'b0);
    @(posedge pclk);
    rx_mode <= 2'h2;
    repeat (1100) @(posedge pclk);
    check("framed all-ones", {26'h0, acts}, 32'h3e);
    rx_mode <= 2'h0;
    apply(6'h00, 1100);
    $display("all-ones done");
  endtask

  task automatic t_excess();
    err_cfg <= 3'h6;
    repeat (320) @(posedge pclk);
    reg_chk(OFF_ERRCNT, 32'd48, 1'b0);
    check("below set threshold", {26'h0, acts}, 32'h0);
    err_cfg <= 3'h7;
    repeat (320) @(posedge pclk);
    reg_chk(OFF_FAULTS, 32'h0000_0082, 1'b0);
    check("excess error actions", {26'h0, acts}, 32'h3e);
    err_cfg <= 3'h4;
    repeat (320) @(posedge pclk);
    check("held above clear threshold", {26'h0, acts}, 32'h3e);
    err_cfg <= 3'h3;
    repeat (320) @(posedge pclk);
    check("cleared", {26'h0, acts}, 32'h0);
    wr(OFF_THRESH, 32'h0010_0018, 1'b0);
    reg_chk(OFF_THRESH, 32'h0010_0018, 1'b0);
    repeat (320) @(posedge pclk);
    check("lowered set threshold", {26'h0, acts}, 32'h3e);
    err_cfg <= 3'h0;
    $display("error monitor done");
  endtask

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, reset, run
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Run is about 5400 cycles; the ceiling leaves ample margin
  always @(posedge pclk) begin
    cyc++;
    ts16_tx_valid <= ~ts16_tx_valid;
    if (cyc == 30000) begin
      failures++;
      test_done();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {power_fail_pin, codec_fail_pin, ts16_in_lost_pin, frame_lost, rx_sig_lost} = '0;
    {err_cfg, ra_cfg, rx_mode, ts16_tx_valid, ts16_tx_in} = '0;
    {failures, n_tests} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_table();
    t_ais();
    t_excess();
    test_done();
  end
endmodule
